// ==== rtl/double_word_arith.sv ====
// double-length fixed and floating arithmetic unit beside the host
`timescale 1ns/1ps
`include "dwa_defs.svh"
// ****************************************************************
// Contract
// RQ1: unit answers only dispatches on channel address 7
// RQ2: runs alone once dispatched; later dispatch waits until done
// RQ3: host passes general words only with bits 5-15 all zero
// RQ4: memory operand address comes from host instruction word
// RQ5: status query is answered for the host branch decision
// RQ6: 20-bit word, opcode bits 0-4, suffix 16-19, address 7-19
// RQ7: double-word load fetches location and the next one
// RQ8: operand meaning follows the selected arithmetic mode
// RQ9: fixed word has 38 bits, two signs; bit 21 forced to bit 1
// RQ10: negative fixed values use two's complement over 40 bits
// RQ11: no disagreeing fixed signs except on overflow or underflow
// RQ12: fixed product spans both accumulators with agreeing signs
// RQ13: float exponent is top 9 bits, sign plus 8 magnitude
// RQ14: float mantissa is 30 low bits, binary point above top bit
// RQ15: exponent range is -256 to +255
// RQ16: positive normalize shifts left until bit 10 set, exp-1 each
// RQ17: negative normalize until bit 10 clear or lone one, exp-1 each
// RQ18: normalized mode normalizes results, accepts raw operands
// RQ19: low half exponent is upper minus 30, same fraction sign
// RQ20: multiply/divide treat zero mantissa as zero, exponent zero
// RQ21: exponent one past range loads, stores, computes as -256
// RQ22: store sends upper 20-bit half first, then lower
// RQ23: 7-bit command from opcode bits 2-4 and suffix 16-19
// RQ24: normalized underflow clears both accumulators, flag stays
// RQ25: busy shows from acceptance until completion
// ****************************************************************
module double_word_arith (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // instruction dispatch from the host
  input  wire logic [2:0]  sel_addr,
  input  wire logic        instr_valid,
  input  wire logic [19:0] instr_word,
  output logic             busy_q,
  // status query
  input  wire logic        query_valid,
  output logic             reply_valid_q,
  output dwa_pkg::status_s reply_q,
  // memory words through host priority control
  output dwa_pkg::mem_req_s mem_q,
  input  wire logic        mem_ack,
  input  wire logic [19:0] mem_rdata,
  // accumulators, mode and indicators
  output dwa_pkg::dword_t  ax_q,
  output dwa_pkg::dword_t  qx_q,
  output dwa_pkg::mode_e   mode_q,
  output logic             overflow_q,
  output logic             underflow_q
);
  // ****************************************************************
  // word formats
  // ****************************************************************
  // fixed value: whole-word sign then 38 bits, two's complement
  function automatic logic signed [38:0] fix_val(input dwa_pkg::dword_t w);
    return {w[`W_HI], w[`W_HI-1:`HALF_LO], w[`MLO_HI:0]}; // RQ10
  endfunction : fix_val

  // repack forcing the second sign to agree with the first
  function automatic dwa_pkg::dword_t fix_pack(input logic [38:0] v);
    return {v[38], v[37:19], v[38], v[18:0]}; // RQ9 RQ11
  endfunction : fix_pack

  // 9-bit exponent; the pattern one below -255 reads as -256
  function automatic logic signed [10:0] flt_exp(input dwa_pkg::dword_t w);
    return {{2{w[`W_HI]}}, w[`W_HI:`EXP_LO]}; // RQ13 RQ15 RQ21
  endfunction : flt_exp

  // fraction sign plus 30 mantissa bits around the sign slot
  function automatic logic signed [30:0] flt_mant(input dwa_pkg::dword_t w);
    return {w[`SM_BIT], w[`MHI_HI:`HALF_LO], w[`MLO_HI:0]}; // RQ14
  endfunction : flt_mant

  function automatic dwa_pkg::dword_t flt_pack(input logic [10:0] e,
                                               input logic s,
                                               input logic [29:0] m);
    return {e[8:0], m[29:19], s, m[18:0]}; // RQ13 RQ14
  endfunction : flt_pack

  // ****************************************************************
  // decode
  // ****************************************************************
  dwa_pkg::state_e          state_q;
  dwa_pkg::dword_t          bx_q;
  logic [6:0]               cmd_q;
  logic signed [10:0]       wexp_q;
  logic signed [61:0]       wm_q;
  logic [2:0]               op;
  logic [3:0]               sfx;
  logic [2:0]               new_op;
  logic [3:0]               new_sfx;
  logic [12:0]              new_addr;
  logic                     accept;
  logic                     new_read;
  logic                     is_arith;
  logic                     is_float;
  logic                     exec_gen;
  logic                     gen_norm;
  logic                     go_norm;
  logic                     finish;

  assign op       = cmd_q[6:4];
  assign sfx      = cmd_q[3:0];
  assign new_op   = instr_word[`OP_HI:`OP_LO]; // RQ6
  assign new_sfx  = instr_word[`SFX_HI:`SFX_LO]; // RQ6
  assign new_addr = instr_word[`ADDR_HI:0]; // RQ6
  // a dispatch while busy is left standing; the host holds its priority
  assign accept   = instr_valid && !busy_q
                    && sel_addr == `UNIT_CHANNEL; // RQ1 RQ2
  assign new_read = new_op == `OPC_LOAD
                    || (new_op >= `OPC_ADD && new_op <= `OPC_DIV);
  assign is_arith = op >= `OPC_ADD && op <= `OPC_DIV;
  assign is_float = mode_q != dwa_pkg::MODE_FIXED; // RQ8
  assign exec_gen = state_q == dwa_pkg::ST_EXEC && op == `OPC_GENERAL;
  assign gen_norm = op == `OPC_GENERAL && sfx == `SFX_NORM;

  // ****************************************************************
  // arithmetic
  // ****************************************************************
  logic signed [38:0] fa;
  logic signed [38:0] fb;
  logic signed [38:0] fq;
  logic signed [38:0] fr;
  logic        [39:0] fs;
  logic signed [77:0] fp;
  logic               fix_ovf;
  logic signed [10:0] ea;
  logic signed [10:0] eb;
  logic signed [10:0] fe;
  logic signed [30:0] ma;
  logic signed [30:0] mb;
  logic signed [61:0] xa;
  logic signed [61:0] xb;
  logic signed [61:0] qt;
  logic signed [61:0] fm;
  logic               f_ovf;

  // fixed point: one extra sign bit catches add overflow
  assign fa = fix_val(ax_q);
  assign fb = fix_val(bx_q);
  assign fs = (op == `OPC_SUB) ? {fa[38], fa} - {fb[38], fb}
                               : {fa[38], fa} + {fb[38], fb};
  assign fp = fa * fb;
  assign fq = (fb == '0) ? '0 : fa / fb;
  assign fr = (fb == '0) ? '0 : fa % fb;
  assign fix_ovf = (op == `OPC_MUL) ? fp[77] != fp[76]
                 : (op == `OPC_DIV) ? fb == '0 : fs[39] != fs[38];

  // floating point in a Q1.60 working mantissa; low bits feed the low half
  always_comb begin
    ea = flt_exp(ax_q);
    eb = flt_exp(bx_q);
    ma = flt_mant(ax_q);
    mb = flt_mant(bx_q);
    if (op == `OPC_MUL || op == `OPC_DIV) begin
      if (ma == '0) ea = '0; // RQ20
      if (mb == '0) eb = '0; // RQ20
    end
    xa = {ma[30], ma, 30'h0};
    xb = {mb[30], mb, 30'h0};
    qt = '0;
    fe = ea;
    fm = '0;
    f_ovf = 1'b0;
    if (op == `OPC_ADD || op == `OPC_SUB) begin
      // the smaller exponent's mantissa shifts right to align
      if (ea >= eb) xb = xb >>> (ea - eb);
      else begin
        xa = xa >>> (eb - ea);
        fe = eb;
      end
      fm = (op == `OPC_SUB) ? xa - xb : xa + xb;
    end else if (op == `OPC_MUL) begin
      fm = ma * mb;
      fe = ea + eb;
    end else if (op == `OPC_DIV) begin
      fe = ea - eb;
      if (mb == '0) f_ovf = 1'b1;
      else begin
        // quotient keeps 30 fraction bits; a ratio of two or more overflows
        qt = xa / 62'(mb);
        f_ovf = qt[61:31] != {31{qt[31]}};
        fm = {qt[31:0], 30'h0};
      end
    end
  end

  // ****************************************************************
  // normalization
  // ****************************************************************
  logic               n_guard;
  logic               n_isnorm;
  logic               n_left;
  logic               n_done;
  logic               r_ovf;
  logic               r_unf;
  logic signed [10:0] res_e;

  assign n_guard  = wm_q[61] != wm_q[60];
  assign n_isnorm = wm_q[60] ? (!wm_q[59] || wm_q[58:0] == '0) // RQ17
                             : wm_q[59]; // RQ16
  assign n_left   = (mode_q == dwa_pkg::MODE_NFLOAT || gen_norm)
                    && !n_isnorm && wm_q != '0; // RQ18
  assign n_done   = state_q == dwa_pkg::ST_NORM && !n_guard && !n_left;
  assign r_ovf    = wexp_q > `EXP_MAX; // RQ15
  assign r_unf    = wexp_q < `EXP_MIN; // RQ15
  assign res_e    = (wm_q == '0) ? '0 : wexp_q;
  assign go_norm  = state_q == dwa_pkg::ST_EXEC
                    && ((is_arith && is_float && !f_ovf) || gen_norm);
  assign finish   = (state_q == dwa_pkg::ST_EXEC && !go_norm) || n_done
                    || (state_q == dwa_pkg::ST_WR2 && mem_ack);

  // ****************************************************************
  // control
  // ****************************************************************
  // sequencer; each memory word waits on its own acknowledge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) state_q <= dwa_pkg::ST_IDLE;
    else begin
      unique case (state_q)
        dwa_pkg::ST_IDLE: begin
          if (accept && new_read) state_q <= dwa_pkg::ST_RD1;
          else if (accept && new_op == `OPC_STORE) state_q <= dwa_pkg::ST_WR1;
          else if (accept) state_q <= dwa_pkg::ST_EXEC;
        end
        dwa_pkg::ST_RD1: if (mem_ack) state_q <= dwa_pkg::ST_RD2;
        dwa_pkg::ST_RD2: if (mem_ack) state_q <= dwa_pkg::ST_EXEC;
        dwa_pkg::ST_WR1: if (mem_ack) state_q <= dwa_pkg::ST_WR2;
        dwa_pkg::ST_WR2: if (mem_ack) state_q <= dwa_pkg::ST_IDLE;
        dwa_pkg::ST_EXEC: begin
          if (go_norm) state_q <= dwa_pkg::ST_NORM;
          else state_q <= dwa_pkg::ST_IDLE;
        end
        dwa_pkg::ST_NORM: if (n_done) state_q <= dwa_pkg::ST_IDLE;
      endcase
    end
  end

  // command capture and busy indication
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_q  <= '0;
      busy_q <= 1'b0;
    end else begin
      if (accept) cmd_q <= {new_op, new_sfx}; // RQ23
      if (accept) busy_q <= 1'b1; // RQ25 RQ2
      else if (finish) busy_q <= 1'b0; // RQ25
    end
  end

  // memory words: operand address from the host instruction word
  always_ff @(posedge clk or posedge reset) begin
    if (reset) mem_q <= '0;
    else begin
      if (accept && (new_read || new_op == `OPC_STORE)) begin
        mem_q.req  <= 1'b1;
        mem_q.we   <= new_op == `OPC_STORE;
        mem_q.addr <= new_addr; // RQ4
        mem_q.wdata <= ax_q[`W_HI:`HALF_LO]; // RQ22
      end
      if ((state_q == dwa_pkg::ST_RD1 || state_q == dwa_pkg::ST_WR1)
          && mem_ack) begin
        mem_q.addr  <= mem_q.addr + `ADDR_STEP; // RQ7
        mem_q.wdata <= bx_q[`HALF_HI:0]; // RQ22
      end
      if ((state_q == dwa_pkg::ST_RD2 || state_q == dwa_pkg::ST_WR2)
          && mem_ack) mem_q.req <= 1'b0;
    end
  end

  // mode selection; fixed point after reset until set otherwise
  always_ff @(posedge clk or posedge reset) begin
    if (reset) mode_q <= dwa_pkg::MODE_FIXED;
    else if (exec_gen && sfx == `SFX_FIX) mode_q <= dwa_pkg::MODE_FIXED;
    else if (exec_gen && sfx == `SFX_NFL) mode_q <= dwa_pkg::MODE_NFLOAT;
    else if (exec_gen && sfx == `SFX_UFL) mode_q <= dwa_pkg::MODE_UFLOAT;
  end

  // hold indicators: a new event wins over a reset in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      overflow_q  <= 1'b0;
      underflow_q <= 1'b0;
    end else begin
      overflow_q <= (state_q == dwa_pkg::ST_EXEC && is_arith
                     && (is_float ? f_ovf : fix_ovf)) || (n_done && r_ovf)
                    || (overflow_q && !(exec_gen && (sfx == `SFX_ROV
                                        || sfx == `SFX_RIN)));
      underflow_q <= (n_done && r_unf) // RQ24
                     || (underflow_q && !(exec_gen && (sfx == `SFX_RUN
                                          || sfx == `SFX_RIN)));
    end
  end

  // status reply, one cycle after the query
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reply_valid_q <= 1'b0;
      reply_q       <= '0;
    end else begin
      reply_valid_q <= query_valid; // RQ5
      if (query_valid) reply_q <= {overflow_q, underflow_q, mode_q, busy_q};
    end
  end

  // ****************************************************************
  // datapath
  // ****************************************************************
  // accumulators, operand buffer and working mantissa
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ax_q   <= '0;
      qx_q   <= '0;
      bx_q   <= '0;
      wm_q   <= '0;
      wexp_q <= '0;
    end else begin
      if (accept && new_op == `OPC_STORE) bx_q <= ax_q; // RQ22
      if (state_q == dwa_pkg::ST_RD1 && mem_ack)
        bx_q[`W_HI:`HALF_LO] <= mem_rdata; // RQ7
      if (state_q == dwa_pkg::ST_RD2 && mem_ack)
        bx_q[`HALF_HI:0] <= mem_rdata; // RQ7
      if (exec_gen) begin
        if (sfx == `SFX_LAQ) ax_q <= qx_q;
        if (sfx == `SFX_LQA || sfx == `SFX_MAQ || sfx == `SFX_XAQ)
          qx_q <= ax_q;
        if (sfx == `SFX_MAQ) ax_q <= '0;
        if (sfx == `SFX_XAQ) ax_q <= qx_q;
        if (sfx == `SFX_NORM) begin
          wm_q   <= {ax_q[`SM_BIT], flt_mant(ax_q), 30'h0};
          wexp_q <= flt_exp(ax_q);
        end
      end
      if (state_q == dwa_pkg::ST_EXEC && op == `OPC_LOAD) ax_q <= bx_q; // RQ7
      if (state_q == dwa_pkg::ST_EXEC && is_arith) begin
        if (is_float) begin // RQ8
          wm_q   <= fm;
          wexp_q <= fe;
        end else if (op == `OPC_MUL) begin
          ax_q <= fix_pack(fp[76:38]); // RQ12
          qx_q <= fix_pack({fp[76], fp[37:0]}); // RQ12
        end else if (op == `OPC_DIV) begin
          if (fb != '0) ax_q <= fix_pack(fq);
          if (fb != '0) qx_q <= fix_pack(fr);
        end else ax_q <= fix_pack(fs[38:0]); // RQ9 RQ10
      end
      // one shift per cycle; mantissa carry shifts right first
      if (state_q == dwa_pkg::ST_NORM) begin
        if (n_guard) begin
          wm_q   <= wm_q >>> 1;
          wexp_q <= wexp_q + 11'sh001;
        end else if (n_left) begin
          wm_q   <= wm_q <<< 1; // RQ16 RQ17
          wexp_q <= wexp_q - 11'sh001; // RQ16 RQ17
        end else if (r_unf && mode_q == dwa_pkg::MODE_NFLOAT) begin
          ax_q <= '0; // RQ24
          qx_q <= '0; // RQ24
        end else begin
          ax_q <= flt_pack(res_e, wm_q[60], wm_q[59:30]);
          qx_q <= flt_pack(res_e - `LO_EXP_OFS, wm_q[60], wm_q[29:0]); // RQ19
        end
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chan_sel_a: assert property (instr_valid && !busy_q // RQ1
    && sel_addr != `UNIT_CHANNEL |=> !busy_q) else $error("wrong channel");
  busy_lock_a: assert property (busy_q && instr_valid |=> $stable(cmd_q)) // RQ2
    else $error("dispatch taken while busy");
  busy_hold_a: assert property (accept |=> busy_q [*2] or (busy_q ##1 // RQ25
    !busy_q)) else $error("busy missing after accept");
  cmd_load_a: assert property (accept |=> cmd_q == // RQ23
    {$past(new_op), $past(new_sfx)}) else $error("command bits wrong");
  op_addr_a: assert property (accept && new_read |=> mem_q.req // RQ4
    && mem_q.addr == $past(new_addr)) else $error("operand address wrong");
  pair_addr_a: assert property (state_q == dwa_pkg::ST_RD1 && mem_ack // RQ7
    |=> mem_q.addr == $past(mem_q.addr) + `ADDR_STEP)
    else $error("second word address wrong");
  store_order_a: assert property (state_q == dwa_pkg::ST_WR1 // RQ22
    |-> mem_q.wdata == bx_q[`W_HI:`HALF_LO]) else $error("store half order");
  reply_a: assert property (query_valid |=> reply_valid_q // RQ5
    && reply_q.overflow == $past(overflow_q)) else $error("no status reply");
  fix_sign_a: assert property (state_q == dwa_pkg::ST_EXEC && is_arith // RQ9
    && !is_float && op != `OPC_DIV |=> ax_q[`W_HI] == ax_q[`SM_BIT])
    else $error("fixed signs disagree");
  mul_sign_a: assert property (state_q == dwa_pkg::ST_EXEC && !is_float // RQ12
    && op == `OPC_MUL |=> qx_q[`W_HI] == ax_q[`W_HI]
    && qx_q[`SM_BIT] == ax_q[`W_HI]) else $error("product signs disagree");
  lo_exp_a: assert property (n_done && !r_unf |=> // RQ19
    qx_q[`W_HI:`EXP_LO] == 9'(flt_exp(ax_q) - `LO_EXP_OFS)
    && qx_q[`SM_BIT] == ax_q[`SM_BIT]) else $error("low half wrong");
  unf_clear_a: assert property (n_done && r_unf // RQ24
    && mode_q == dwa_pkg::MODE_NFLOAT |=> ax_q == '0 && qx_q == '0
    && underflow_q) else $error("underflow did not clear");
  norm_pos_a: assert property (n_done && mode_q == dwa_pkg::MODE_NFLOAT // RQ16
    && !wm_q[60] && wm_q != '0 && !r_unf |=> ax_q[`MHI_HI])
    else $error("positive result not normalized");
  zero_mul_a: assert property (state_q == dwa_pkg::ST_EXEC && is_float // RQ20
    && op == `OPC_MUL && flt_mant(bx_q) == '0 |=> wm_q == '0)
    else $error("zero operand not zero");

  load_c: cover property (state_q == dwa_pkg::ST_RD2 && mem_ack);
  store_c: cover property (state_q == dwa_pkg::ST_WR2 && mem_ack);
  shift_c: cover property (state_q == dwa_pkg::ST_NORM && n_left [*3]);
  unf_c: cover property (n_done && r_unf);
endmodule : double_word_arith

// ==== include/dwa_defs.svh ====
// named constants of the double-length arithmetic unit
`ifndef DWA_DEFS_SVH
`define DWA_DEFS_SVH
`define UNIT_CHANNEL 3'h7
`define OP_HI        17
`define OP_LO        15
`define SFX_HI       3
`define SFX_LO       0
`define ADDR_HI      12
`define W_HI         39
`define HALF_LO      20
`define HALF_HI      19
`define EXP_LO       31
`define MHI_HI       30
`define SM_BIT       19
`define MLO_HI       18
`define OPC_GENERAL  3'h0
`define OPC_LOAD     3'h1
`define OPC_STORE    3'h2
`define OPC_ADD      3'h3
`define OPC_SUB      3'h4
`define OPC_MUL      3'h5
`define OPC_DIV      3'h6
`define SFX_FIX      4'h1
`define SFX_NFL      4'h2
`define SFX_UFL      4'h3
`define SFX_LAQ      4'h4
`define SFX_LQA      4'h5
`define SFX_MAQ      4'h6
`define SFX_XAQ      4'h7
`define SFX_ROV      4'h8
`define SFX_RUN      4'h9
`define SFX_RIN      4'hA
`define SFX_NORM     4'hB
`define LO_EXP_OFS   11'sh01E
`define EXP_MAX      11'sh0FF
`define EXP_MIN      11'sh700
`define ADDR_STEP    13'h0001
`endif

// ==== include/dwa_pkg.sv ====
// shared types of the double-length arithmetic unit
package dwa_pkg;
  typedef logic [39:0] dword_t;
  typedef enum logic [1:0] {MODE_FIXED, MODE_NFLOAT, MODE_UFLOAT} mode_e;
  typedef enum logic [2:0] {ST_IDLE, ST_RD1, ST_RD2, ST_WR1, ST_WR2,
                            ST_EXEC, ST_NORM} state_e;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [12:0] addr;
    logic [19:0] wdata;
  } mem_req_s;
  typedef struct packed {
    logic  overflow;
    logic  underflow;
    mode_e mode;
    logic  busy;
  } status_s;
endpackage : dwa_pkg

// ==== dv/host_mem_model.sv ====
// host memory behind priority control, serving the unit's word requests
`timescale 1ns/1ps
module host_mem_model (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // word requests and grant pacing
  input  wire dwa_pkg::mem_req_s mem,
  input  wire logic [3:0]        delay,
  output logic                   ack,
  output logic [19:0]            rdata
);
  logic [19:0] words [0:1023];
  logic [3:0]  wait_q;
  logic [25:0] alog;
  // one grant per word; read data flips between grants so stale
  // words are never mistaken for fresh ones
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ack <= 1'b0;
      rdata <= 20'h0;
      wait_q <= 4'h0;
    end else if (ack) begin
      ack <= 1'b0;
      wait_q <= 4'h0;
      rdata <= ~rdata;
    end else if (mem.req && wait_q >= delay) begin
      ack <= 1'b1;
      alog <= {alog[12:0], mem.addr};
      if (mem.we) begin
        words[mem.addr[9:0]] <= mem.wdata;
      end else begin
        rdata <= words[mem.addr[9:0]];
      end
    end else begin
      rdata <= ~rdata;
      wait_q <= mem.req ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule : host_mem_model

// ==== dv/tb_double_word_arith.sv ====
// self-checking bench of the double-length arithmetic unit
`timescale 1ns/1ps
`include "dwa_defs.svh"
module tb_double_word_arith;
  // ****
  // signals
  // ****
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic [2:0]        sel_addr = 3'h0;
  logic              instr_valid = 1'b0;
  logic [19:0]       instr_word = 20'h0;
  logic              query_valid = 1'b0;
  logic [3:0]        delay = 4'h0;
  logic              busy_q, reply_valid_q, mem_ack;
  logic [19:0]       mem_rdata;
  dwa_pkg::status_s  reply_q;
  dwa_pkg::mem_req_s mem_q;
  dwa_pkg::dword_t   ax_q, qx_q;
  dwa_pkg::mode_e    mode_q;
  logic              overflow_q, underflow_q;
  int                num_errors = 0;
  int                check_count = 0;
  int                cycles = 0;
  double_word_arith dut (.clk(clk), .reset(reset), .sel_addr(sel_addr),
    .instr_valid(instr_valid), .instr_word(instr_word), .busy_q(busy_q),
    .query_valid(query_valid), .reply_valid_q(reply_valid_q),
    .reply_q(reply_q), .mem_q(mem_q), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .ax_q(ax_q), .qx_q(qx_q), .mode_q(mode_q),
    .overflow_q(overflow_q), .underflow_q(underflow_q));
  host_mem_model host (.clk(clk), .reset(reset), .mem(mem_q),
    .delay(delay), .ack(mem_ack), .rdata(mem_rdata));
  // ****
  // clock, reset, hang guard
  // ****
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
  end
  // the whole run needs a few hundred cycles; this is generous
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end
  // ****
  // tasks
  // ****
  task automatic chk(input string nm, input logic [39:0] e,
                     input logic [39:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [19:0] gen(input logic [3:0] s);
    return {16'h0, s};
  endfunction : gen
  // waits on falling edges so busy is read settled
  task automatic idle();
    int n;
    n = 0;
    @(negedge clk);
    while (busy_q !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("idle", 40'h0, {39'h0, busy_q});
  endtask : idle
  task automatic run(input logic [2:0] s, input logic [19:0] w);
    @(posedge clk);
    sel_addr <= s;
    instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge clk);
    instr_valid <= 1'b0;
    idle();
  endtask : run
  // operand placed at a; bits 13-14 set since the unit ignores them
  task automatic mop(input logic [2:0] o, input logic [12:0] a,
                     input logic [39:0] v);
    host.words[a[9:0]] = v[39:20];
    host.words[a[9:0] + 10'h1] = v[19:0];
    run(3'h7, {2'h0, o, 2'h3, a});
  endtask : mop
  task automatic query(input logic [4:0] e);
    @(posedge clk);
    query_valid <= 1'b1;
    @(posedge clk);
    query_valid <= 1'b0;
    @(negedge clk);
    chk("reply_valid", 40'h1, {39'h0, reply_valid_q});
    chk("reply", {35'h0, e}, {35'h0, reply_q});
    @(negedge clk);
    chk("reply_pulse", 40'h0, {39'h0, reply_valid_q});
  endtask : query
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  // ****
  // tests
  // ****
  initial begin
    repeat (5) @(posedge clk);
    run(3'h3, gen(`SFX_NFL));
    chk("mode", 40'h0, {38'h0, mode_q});
    for (int s = 3; s >= 1; s--) begin
      run(3'h7, gen(4'(s)));
      chk("mode", 40'(s - 1), {38'h0, mode_q});
      query({2'h0, 2'(s - 1), 1'b0});
    end
    $display("test modes done");
    mop(`OPC_LOAD, 13'h010, 40'h0123405678);
    chk("ax", 40'h0123405678, ax_q);
    chk("alog", {13'h010, 13'h011}, {14'h0, host.alog});
    delay <= 4'h3;
    run(3'h7, {2'h0, `OPC_STORE, 2'h0, 13'h020});
    chk("st_hi", 40'h01234, {20'h0, host.words[10'h020]});
    chk("st_lo", 40'h05678, {20'h0, host.words[10'h021]});
    chk("alog", {13'h020, 13'h021}, {14'h0, host.alog});
    // a held dispatch must wait until the slow load finishes
    @(posedge clk);
    sel_addr <= 3'h7;
    instr_valid <= 1'b1;
    instr_word <= {2'h0, `OPC_LOAD, 2'h0, 13'h010};
    @(posedge clk);
    instr_word <= gen(`SFX_UFL);
    repeat (6) @(negedge clk);
    chk("busy", 40'h1, {39'h0, busy_q});
    chk("mode", 40'h0, {38'h0, mode_q});
    idle();
    @(posedge clk);
    instr_valid <= 1'b0;
    idle();
    chk("mode", 40'h2, {38'h0, mode_q});
    $display("test transfer done");
    delay <= 4'h0;
    run(3'h7, gen(`SFX_FIX));
    mop(`OPC_LOAD, 13'h030, 40'h5);
    mop(`OPC_ADD, 13'h100, 40'h0000080000);
    chk("fx_add", 40'h5, ax_q);
    mop(`OPC_SUB, 13'h100, 40'h7);
    chk("fx_sub", 40'hFFFFFFFFFE, ax_q);
    mop(`OPC_MUL, 13'h100, 40'h1);
    chk("mul_hi", 40'hFFFFFFFFFF, ax_q);
    chk("mul_lo", 40'hFFFFFFFFFE, qx_q);
    mop(`OPC_DIV, 13'h100, 40'h0);
    chk("div0", 40'hFFFFFFFFFF, ax_q);
    query({2'h2, dwa_pkg::MODE_FIXED, 1'b0});
    run(3'h7, gen(`SFX_RIN));
    chk("ovf", 40'h0, {39'h0, overflow_q});
    mop(`OPC_DIV, 13'h100, 40'h0);
    chk("ovf_set", 40'h1, {39'h0, overflow_q});
    run(3'h7, gen(`SFX_ROV));
    chk("rov", 40'h0, {39'h0, overflow_q});
    mop(`OPC_LOAD, 13'h030, 40'h0000300003);
    run(3'h7, gen(`SFX_MAQ));
    chk("maq_ax", 40'h0, ax_q);
    chk("maq_qx", 40'h0000300003, qx_q);
    mop(`OPC_LOAD, 13'h030, 40'h5);
    run(3'h7, gen(`SFX_XAQ));
    chk("xaq_ax", 40'h0000300003, ax_q);
    chk("xaq_qx", 40'h5, qx_q);
    run(3'h7, gen(`SFX_LQA));
    chk("lqa", 40'h0000300003, qx_q);
    mop(`OPC_LOAD, 13'h030, 40'h5);
    run(3'h7, gen(`SFX_LAQ));
    chk("laq", 40'h0000300003, ax_q);
    $display("test fixed done");
    run(3'h7, gen(`SFX_NFL));
    mop(`OPC_LOAD, 13'h030, {9'h005, 11'h080, 20'h0});
    run(3'h7, gen(`SFX_NORM));
    chk("norm_pos", {9'h002, 11'h400, 20'h0}, ax_q);
    mop(`OPC_LOAD, 13'h030, {9'h005, 11'h700, 1'b1, 19'h0});
    run(3'h7, gen(`SFX_NORM));
    chk("norm_neg", {9'h003, 11'h400, 1'b1, 19'h0}, ax_q);
    mop(`OPC_LOAD, 13'h030, {9'h001, 11'h400, 20'h0});
    mop(`OPC_ADD, 13'h100, {9'h001, 11'h400, 20'h0});
    chk("fl_add", {9'h002, 11'h400, 20'h0}, ax_q);
    chk("fl_add_lo", {9'h1E4, 31'h0}, qx_q);
    mop(`OPC_LOAD, 13'h030, {9'h001, 11'h400, 20'h0});
    mop(`OPC_SUB, 13'h100, {9'h001, 11'h200, 20'h0});
    chk("fl_sub", {9'h000, 11'h400, 20'h0}, ax_q);
    chk("fl_sub_lo", {9'h1E2, 31'h0}, qx_q);
    mop(`OPC_MUL, 13'h100, {9'h005, 31'h0});
    chk("zero_mul", 40'h0, ax_q);
    mop(`OPC_LOAD, 13'h030, {9'h100, 11'h400, 20'h0});
    mop(`OPC_MUL, 13'h100, {9'h1FF, 11'h400, 20'h0});
    chk("unf_ax", 40'h0, ax_q);
    chk("unf_qx", 40'h0, qx_q);
    query({2'h1, dwa_pkg::MODE_NFLOAT, 1'b0});
    run(3'h7, gen(`SFX_RUN));
    chk("unf", 40'h0, {39'h0, underflow_q});
    $display("test float done");
    close_out();
  end
endmodule : tb_double_word_arith
